// ===== hdl/mcp_pkg.sv
package mcp_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [8:0] CODE_STORE = 9'h12C;
  localparam logic [8:0] CODE_UNIT = 9'h12D;
  localparam logic [8:0] CODE_SPIN_RATIO = 9'h136;
  localparam logic [8:0] CODE_SOFT_EN = 9'h137;
  localparam logic [8:0] CODE_SOFT_FIRST = 9'h138;
  localparam logic [8:0] CODE_SOFT_LAST = 9'h13D;
  localparam logic [8:0] CODE_HOME_FIRST = 9'h13E;
  localparam logic [8:0] CODE_HOME_LAST = 9'h140;

  // ----------------------------------------------------------------
  // nonvolatile layout: word index = code minus the unit code
  // ----------------------------------------------------------------
  localparam int NV_AW = 4;
  localparam logic [3:0] NV_IDX_UNIT = 4'h0;
  localparam logic [3:0] NV_IDX_RATIO_X = 4'h1;
  localparam logic [3:0] NV_IDX_RATIO_Z = 4'h3;
  localparam logic [3:0] NV_IDX_LIM = 4'h4;
  localparam logic [3:0] NV_IDX_HOME = 4'h5;
  localparam logic [3:0] NV_IDX_DIR = 4'h6;
  localparam logic [3:0] NV_IDX_IN = 4'h7;
  localparam logic [3:0] NV_IDX_ID = 4'h8;
  localparam logic [3:0] NV_IDX_SPIN = 4'h9;
  localparam logic [3:0] NV_IDX_MARK = 4'hA;
  localparam logic [31:0] NV_MARK = 32'h5A5A_0001;

  // ----------------------------------------------------------------
  // reset values and ranges
  // ----------------------------------------------------------------
  localparam logic UNIT_DEF = 1'b0;
  localparam logic [31:0] RATIO_DEF = 32'h0000_03E8;
  localparam logic [2:0] MASK_DEF = 3'h0;
  localparam logic [6:0] ID_DEF = 7'h00;
  localparam logic [31:0] ID_MAX = 32'h0000_0063;
  localparam logic [31:0] SOFT_NEG_DEF = 32'hFFFF_FFFF;
  localparam logic [31:0] SOFT_POS_DEF = 32'h0000_0001;
  localparam logic [2:0] HOMING_DEF = 3'h0;
  localparam logic [7:0] ERR_RANGE = 8'h01;
  localparam logic [7:0] ERR_UNKNOWN = 8'h02;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [8:0] code;
    logic [31:0] value;
  } mcp_cmd_s;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [7:0] err;
    logic [31:0] value;
  } mcp_reply_s;

  typedef struct packed {
    logic unit;
    logic [2:0][31:0] ratio;
    logic [2:0] lim_pol;
    logic [2:0] home_pol;
    logic [2:0] dir_pol;
    logic [2:0] in_pol;
    logic [6:0] id;
    logic [31:0] spin_ratio;
  } mcp_persist_s;

  typedef struct packed {
    logic soft_en;
    logic [2:0][31:0] soft_neg;
    logic [2:0][31:0] soft_pos;
    logic [2:0] homing;
  } mcp_volatile_s;

  typedef enum logic [2:0] {
    ST_MARK_RD, ST_MARK_CHK, ST_LOAD_RD, ST_LOAD_APPLY, ST_IDLE, ST_STORE
  } mcp_state_e;

endpackage

// ===== hdl/mcp_nv_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// nonvolatile word store; array has no reset so contents survive rst
// ------------------------------------------------------------------
module mcp_nv_mem (
  // clock
  input wire logic clk,
  // write side
  input wire logic we,
  input wire logic [mcp_pkg::NV_AW-1:0] waddr,
  input wire logic [31:0] wdata,
  // read side
  input wire logic [mcp_pkg::NV_AW-1:0] raddr,
  output logic [31:0] rdata
);
  import mcp_pkg::*;

  logic [31:0] mem [0:(1<<NV_AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

// ===== hdl/mcp_param_store.sv
// Functional notes
// - after reset, persistent group is read from nonvolatile store and applied
// - store command writes the persistent group to nonvolatile store
// - volatile parameters never stored; reset sets them to defaults
// - soft limiting off after reset; limits default to -1 and 1
// - homing modes default 0 (limit only); 1 means home and limit
// - command code alone returns the parameter's current value
// - code with value writes it; reply ok or error code
// - system unit 0 is millimetre, 1 is inch
// - separate working unit set by motion commands at any time
// - per-axis ratio converts commanded distance into pulse count
// - each axis gets its own pulse count from its own ratio
// - arc command with unequal X and Y ratios flags buffer error
// - step and direction outputs per axis
// - direction mask bits invert X, Y, Z direction outputs
// - limit mask sets active level of plus and minus limits
// - home mask sets active level of each home input
// - three general inputs with their own polarity mask
// - unit identifier 0 to 99, default 0
// - spindle step/direction, rate is speed times spindle ratio
// - enabled soft limit violation while running flags buffer error
`timescale 1ns/1ps
`default_nettype none

module mcp_param_store (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // parsed host command and reply
  input wire mcp_pkg::mcp_cmd_s cmd,
  output logic cmd_ready,
  output mcp_pkg::mcp_reply_s reply,
  // parameter view
  output mcp_pkg::mcp_persist_s persist,
  output mcp_pkg::mcp_volatile_s volat,
  output logic working_unit,
  // motion engine side
  input wire logic gcode_unit_set,
  input wire logic gcode_unit_val,
  input wire logic move_load,
  input wire logic [2:0][15:0] move_dist,
  output logic [2:0][31:0] pulse_count,
  input wire logic [15:0] spin_speed,
  output logic [31:0] spin_rate,
  input wire logic arc_exec,
  input wire logic soft_violation,
  input wire logic buf_running,
  output logic buf_error,
  // step and direction
  input wire logic [2:0] step_req,
  input wire logic [2:0] dir_raw,
  input wire logic spin_step_req,
  input wire logic spin_dir_raw,
  output logic [2:0] step_pulse_out,
  output logic [2:0] dir_out,
  output logic spin_step_out,
  output logic spin_dir_out,
  // input pins and qualified levels
  input wire logic [2:0] limit_plus_in,
  input wire logic [2:0] limit_minus_in,
  input wire logic [2:0] home_in,
  input wire logic [2:0] general_input,
  output logic [11:0] input_active
);
  import mcp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mcp_state_e st;
    logic [3:0] cnt;
    mcp_persist_s p;
    mcp_volatile_s v;
    logic work_unit;
    mcp_reply_s rep;
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] active;
    logic [2:0] step;
    logic [2:0] dir;
    logic spin_step;
    logic spin_dir;
    logic [2:0][31:0] pcount;
    logic [31:0] srate;
    logic berr;
  } mcp_regs_s;

  mcp_regs_s r_q, r_d;
  logic nv_we;
  logic [NV_AW-1:0] nv_waddr, nv_raddr;
  logic [31:0] nv_wdata, nv_rdata;

  mcp_nv_mem u_nv (
    .clk(clk),
    .we(nv_we),
    .waddr(nv_waddr),
    .wdata(nv_wdata),
    .raddr(nv_raddr),
    .rdata(nv_rdata)
  );

  // ----------------------------------------------------------------
  // persistent word packing
  // ----------------------------------------------------------------
  function automatic logic [31:0] word_of(input mcp_persist_s p, input logic [3:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (idx)
      NV_IDX_UNIT: w = {31'h0, p.unit};
      4'h1, 4'h2, NV_IDX_RATIO_Z: w = p.ratio[2'(idx - NV_IDX_RATIO_X)];
      NV_IDX_LIM: w = {29'h0, p.lim_pol};
      NV_IDX_HOME: w = {29'h0, p.home_pol};
      NV_IDX_DIR: w = {29'h0, p.dir_pol};
      NV_IDX_IN: w = {29'h0, p.in_pol};
      NV_IDX_ID: w = {25'h0, p.id};
      NV_IDX_SPIN: w = p.spin_ratio;
      default: w = NV_MARK;
    endcase
    return w;
  endfunction

  function automatic mcp_persist_s put_word(input mcp_persist_s p, input logic [3:0] idx,
                                            input logic [31:0] w);
    mcp_persist_s o;
    o = p;
    unique case (idx)
      NV_IDX_UNIT: o.unit = w[0];
      4'h1, 4'h2, NV_IDX_RATIO_Z: o.ratio[2'(idx - NV_IDX_RATIO_X)] = w;
      NV_IDX_LIM: o.lim_pol = w[2:0];
      NV_IDX_HOME: o.home_pol = w[2:0];
      NV_IDX_DIR: o.dir_pol = w[2:0];
      NV_IDX_IN: o.in_pol = w[2:0];
      NV_IDX_ID: o.id = w[6:0];
      NV_IDX_SPIN: o.spin_ratio = w;
      default: o = p;
    endcase
    return o;
  endfunction

  // unit 0/1, ratios nonzero, masks 3 bits, id 0..99, flags 0/1
  function automatic logic value_ok(input logic [8:0] code, input logic [31:0] v);
    logic ok;
    ok = 1'b1;
    if (code == CODE_UNIT || code == CODE_SOFT_EN || code >= CODE_HOME_FIRST)
      ok = (v < 32'h0000_0002);
    else if (code == 9'h12E || code == 9'h12F || code == 9'h130 || code == CODE_SPIN_RATIO)
      ok = (v != 32'h0000_0000);
    else if (code >= 9'h131 && code <= 9'h134)
      ok = (v < 32'h0000_0008);
    else if (code == 9'h135)
      ok = (v <= ID_MAX);
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [3:0] cidx;
  logic known;
  logic signed [48:0] prod;
  logic [47:0] sprod;

  always_comb
  begin
    r_d = r_q;
    cidx = 4'(cmd.code - CODE_UNIT);
    known = (cmd.code >= CODE_STORE) && (cmd.code <= CODE_HOME_LAST);
    prod = 49'sh0;
    sprod = 48'h0;
    nv_we = 1'b0;
    nv_waddr = r_q.cnt;
    nv_wdata = word_of(r_q.p, r_q.cnt);
    nv_raddr = (r_q.st == ST_MARK_RD) ? NV_IDX_MARK : r_q.cnt;
    r_d.rep.valid = 1'b0;
    r_d.berr = 1'b0;
    unique case (r_q.st)
      ST_MARK_RD: r_d.st = ST_MARK_CHK;
      // blank store keeps the defaults already in place
      ST_MARK_CHK:
      begin
        r_d.cnt = 4'h0;
        // a never-written store reads unknown; that must fall to idle, not poison the state
        if (nv_rdata == NV_MARK)
          r_d.st = ST_LOAD_RD;
        else
          r_d.st = ST_IDLE;
      end
      ST_LOAD_RD: r_d.st = ST_LOAD_APPLY;
      ST_LOAD_APPLY:
      begin
        r_d.p = put_word(r_q.p, r_q.cnt, nv_rdata);
        r_d.cnt = r_q.cnt + 4'h1;
        r_d.st = (r_q.cnt == NV_IDX_SPIN) ? ST_IDLE : ST_LOAD_RD;
      end
      ST_STORE:
      begin
        nv_we = 1'b1;
        r_d.cnt = r_q.cnt + 4'h1;
        if (r_q.cnt == NV_IDX_MARK)
        begin
          r_d.st = ST_IDLE;
          r_d.rep = '{valid: 1'b1, ok: 1'b1, err: 8'h00, value: 32'h0};
        end
      end
      ST_IDLE:
      begin
        if (cmd.valid)
        begin
          r_d.rep = '{valid: 1'b1, ok: 1'b1, err: 8'h00, value: 32'h0};
          if (!known)
          begin
            r_d.rep.ok = 1'b0;
            r_d.rep.err = ERR_UNKNOWN;
          end
          else if (cmd.code == CODE_STORE)
          begin
            r_d.rep.valid = 1'b0;
            r_d.cnt = 4'h0;
            r_d.st = ST_STORE;
          end
          else if (!cmd.write)
          begin
            if (cmd.code <= CODE_SPIN_RATIO)
              r_d.rep.value = word_of(r_q.p, cidx);
            else if (cmd.code == CODE_SOFT_EN)
              r_d.rep.value = {31'h0, r_q.v.soft_en};
            else if (cmd.code <= CODE_SOFT_LAST)
              r_d.rep.value = cmd.code[0] ? r_q.v.soft_pos[2'((cmd.code - 9'h139) >> 1)]
                                          : r_q.v.soft_neg[2'((cmd.code - 9'h138) >> 1)];
            else
              r_d.rep.value = {31'h0, r_q.v.homing[2'(cmd.code - CODE_HOME_FIRST)]};
          end
          else if (!value_ok(cmd.code, cmd.value))
          begin
            r_d.rep.ok = 1'b0;
            r_d.rep.err = ERR_RANGE;
          end
          else if (cmd.code <= CODE_SPIN_RATIO)
            r_d.p = put_word(r_q.p, cidx, cmd.value);
          else if (cmd.code == CODE_SOFT_EN)
            r_d.v.soft_en = cmd.value[0];
          else if (cmd.code <= CODE_SOFT_LAST)
          begin
            if (cmd.code[0])
              r_d.v.soft_pos[2'((cmd.code - 9'h139) >> 1)] = cmd.value;
            else
              r_d.v.soft_neg[2'((cmd.code - 9'h138) >> 1)] = cmd.value;
          end
          else
            r_d.v.homing[2'(cmd.code - CODE_HOME_FIRST)] = cmd.value[0];
        end
      end
    endcase
    // working unit is independent of the stored system unit
    if (gcode_unit_set)
      r_d.work_unit = gcode_unit_val;
    if (move_load)
    begin
      for (int i = 0; i < 3; i++)
      begin
        prod = $signed(move_dist[i]) * $signed({1'b0, r_q.p.ratio[i]});
        r_d.pcount[i] = prod[31:0];
      end
    end
    sprod = spin_speed * r_q.p.spin_ratio;
    r_d.srate = sprod[31:0];
    // ratio check costs nothing here, so arcs are checked every time
    if (arc_exec && r_q.p.ratio[0] != r_q.p.ratio[1])
      r_d.berr = 1'b1;
    if (r_q.v.soft_en && soft_violation && buf_running)
      r_d.berr = 1'b1;
    r_d.step = step_req;
    r_d.dir = dir_raw ^ r_q.p.dir_pol;
    r_d.spin_step = spin_step_req;
    r_d.spin_dir = spin_dir_raw;
    r_d.sync1 = {general_input, home_in, limit_minus_in, limit_plus_in};
    r_d.sync2 = r_q.sync1;
    // mask bit 1 means the pin is active high
    r_d.active = r_q.sync2 ~^ {r_q.p.in_pol, r_q.p.home_pol, r_q.p.lim_pol, r_q.p.lim_pol};
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r_q <= '0;
      r_q.st <= ST_MARK_RD;
      r_q.p <= '{unit: UNIT_DEF, ratio: {3{RATIO_DEF}}, lim_pol: MASK_DEF, home_pol: MASK_DEF,
                 dir_pol: MASK_DEF, in_pol: MASK_DEF, id: ID_DEF, spin_ratio: RATIO_DEF};
      r_q.v <= '{soft_en: 1'b0, soft_neg: {3{SOFT_NEG_DEF}}, soft_pos: {3{SOFT_POS_DEF}},
                 homing: HOMING_DEF};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign cmd_ready = (r_q.st == ST_IDLE);
  assign reply = r_q.rep;
  assign persist = r_q.p;
  assign volat = r_q.v;
  assign working_unit = r_q.work_unit;
  assign pulse_count = r_q.pcount;
  assign spin_rate = r_q.srate;
  assign buf_error = r_q.berr;
  assign step_pulse_out = r_q.step;
  assign dir_out = r_q.dir;
  assign spin_step_out = r_q.spin_step;
  assign spin_dir_out = r_q.spin_dir;
  assign input_active = r_q.active;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_boot_load_done: assert property ($fell(rst) |-> ##[1:24] cmd_ready)
    else $error("load after reset did not finish");
  a_store_writes: assert property (cmd_ready && cmd.valid && cmd.code == CODE_STORE
      |=> nv_we [*8])
    else $error("store command did not write the group");
  a_volatile_def: assert property ($fell(rst) |-> !volat.soft_en && volat.homing == 3'h0
      && volat.soft_neg[0] == SOFT_NEG_DEF && volat.soft_pos[2] == SOFT_POS_DEF)
    else $error("volatile parameters not at default after reset");
  a_query_unit: assert property (cmd_ready && cmd.valid && !cmd.write && cmd.code == CODE_UNIT
      |=> reply.valid && reply.ok && reply.value == {31'h0, $past(persist.unit)})
    else $error("unit query returned wrong value");
  a_write_unit: assert property (cmd_ready && cmd.valid && cmd.write && cmd.code == CODE_UNIT
      && cmd.value < 32'h2 |=> reply.ok && persist.unit == $past(cmd.value[0]))
    else $error("unit write not applied");
  a_bad_id_kept: assert property (cmd_ready && cmd.valid && cmd.write && cmd.code == 9'h135
      && cmd.value > ID_MAX |=> reply.valid && !reply.ok && $stable(persist.id))
    else $error("out of range identifier accepted");
  a_dir_polarity: assert property (##1 dir_out == $past(dir_raw ^ persist.dir_pol))
    else $error("direction polarity wrong");
  a_arc_ratio: assert property (arc_exec && persist.ratio[0] != persist.ratio[1]
      |=> buf_error)
    else $error("arc with unequal ratios not flagged");
  a_soft_error: assert property (buf_error |-> $past(arc_exec)
      || $past(volat.soft_en && soft_violation && buf_running))
    else $error("buffer error without cause");

  c_store: cover property (cmd_ready && cmd.valid && cmd.code == CODE_STORE ##12 reply.ok);
  c_bad_write: cover property (reply.valid && !reply.ok && reply.err == ERR_RANGE);
  c_arc_error: cover property (arc_exec ##1 buf_error);

endmodule

`default_nettype wire

// ===== tb/mcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module mcp_host_model (
  // clock
  input wire logic clk,
  // command link
  output var mcp_pkg::mcp_cmd_s cmd,
  input wire logic cmd_ready,
  input wire mcp_pkg::mcp_reply_s reply
);
  import mcp_pkg::*;

  // ----------------------------------------------------------------
  // host side of the command link
  // ----------------------------------------------------------------
  initial cmd = '0;

  // released fields show the inverse so a stale value never looks live
  task automatic send(input logic wr, input logic [8:0] code, input logic [31:0] val,
                      output mcp_reply_s r, output logic got);
    int n;
    logic take;
    got = 1'b0;
    r = '0;
    take = 1'b0;
    n = 0;
    @(posedge clk);
    #1;
    cmd = {1'b1, wr, code, val};
    while (!take && n < 64)
    begin
      take = (cmd_ready === 1'b1);
      @(posedge clk);
      n++;
    end
    #1;
    cmd = {1'b0, ~wr, ~code, ~val};
    n = 0;
    while (take && !got && n < 24)
    begin
      if (reply.valid === 1'b1)
      begin
        r = reply;
        got = 1'b1;
      end
      else
      begin
        @(posedge clk);
        #1;
      end
      n++;
    end
  endtask
endmodule

`default_nettype wire

// ===== tb/tb_motion_config_parameter_store.sv
`timescale 1ns/1ps
`default_nettype none

module tb_motion_config_parameter_store;
  import mcp_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic clk, rst, cmd_ready, working_unit, gcode_unit_set, gcode_unit_val;
  logic move_load, arc_exec, soft_violation, buf_running, buf_error;
  logic spin_step_req, spin_dir_raw, spin_step_out, spin_dir_out;
  logic [2:0] step_req, dir_raw, step_pulse_out, dir_out;
  logic [2:0] limit_plus_in, limit_minus_in, home_in, general_input;
  logic [11:0] input_active;
  logic [15:0] spin_speed;
  logic [31:0] spin_rate;
  logic [2:0][15:0] move_dist;
  logic [2:0][31:0] pulse_count;
  mcp_cmd_s cmd;
  mcp_reply_s reply;
  mcp_persist_s persist;
  mcp_volatile_s volat;
  int n_fail = 0;
  int samples_checked = 0;

  mcp_param_store dut_u (
    .clk, .rst, .cmd, .cmd_ready, .reply, .persist, .volat, .working_unit,
    .gcode_unit_set, .gcode_unit_val, .move_load, .move_dist, .pulse_count,
    .spin_speed, .spin_rate, .arc_exec, .soft_violation, .buf_running, .buf_error,
    .step_req, .dir_raw, .spin_step_req, .spin_dir_raw, .step_pulse_out, .dir_out,
    .spin_step_out, .spin_dir_out, .limit_plus_in, .limit_minus_in, .home_in,
    .general_input, .input_active
  );
  mcp_host_model host_u (.clk, .cmd, .cmd_ready, .reply);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic power_up;
    int n;
    n = 0;
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    // loading from the store can take over twenty cycles
    while (cmd_ready !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (cmd_ready !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] cmd_ready expected 1 seen %b", cmd_ready);
      end_of_test();
    end
  endtask

  task automatic io(input logic w, input logic [8:0] c, input logic [31:0] v,
                    output mcp_reply_s r);
    logic got;
    host_u.send(w, c, v, r, got);
    if (got !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] reply to code %h expected 1 seen %b", c, got);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [8:0] c, input logic [31:0] v);
    mcp_reply_s r;
    io(1'b1, c, v, r);
    chk($sformatf("write ok %h", c), 32'h1, 32'(r.ok));
  endtask

  task automatic bad(input logic [8:0] c, input logic [31:0] v, input logic [7:0] e);
    mcp_reply_s r;
    io(1'b1, c, v, r);
    chk($sformatf("refused ok %h", c), 32'h0, 32'(r.ok));
    chk($sformatf("error code %h", c), 32'(e), 32'(r.err));
  endtask

  task automatic q(input logic [8:0] c, input logic [31:0] e);
    mcp_reply_s r;
    io(1'b0, c, 32'h0, r);
    chk($sformatf("query %h", c), e, r.value);
  endtask

  // one cycle of cause, then count error pulses over three cycles
  task automatic err_pulses(input logic a, input logic s, output int k);
    k = 0;
    @(posedge clk);
    #1;
    arc_exec = a;
    soft_violation = s;
    repeat (3)
    begin
      @(posedge clk);
      #1;
      arc_exec = 1'b0;
      soft_violation = 1'b0;
      k += int'(buf_error === 1'b1);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int k;
    mcp_reply_s r;
    logic [11:0] e;
    rst = 1'b1;
    {gcode_unit_set, gcode_unit_val, move_load, arc_exec, soft_violation} = '0;
    {buf_running, spin_step_req, spin_dir_raw, step_req, dir_raw} = '0;
    {limit_plus_in, limit_minus_in, home_in, general_input} = '0;
    move_dist = '0;
    spin_speed = '0;
    power_up();
    // defaults after power-up with a blank store
    chk("unit", 32'h0, 32'(persist.unit));
    chk("ratio x", RATIO_DEF, persist.ratio[0]);
    chk("soft enable", 32'h0, 32'(volat.soft_en));
    for (int i = 0; i < 6; i++)
      q(CODE_SOFT_FIRST + 9'(i), i[0] ? 32'h1 : 32'hFFFF_FFFF);
    for (int i = 0; i < 3; i++)
      q(CODE_HOME_FIRST + 9'(i), 32'h0);
    q(9'h135, 32'h0);
    // writes, refusals and range limits
    wr(CODE_UNIT, 32'h1);
    chk("unit inch", 32'h1, 32'(persist.unit));
    bad(CODE_UNIT, 32'h2, ERR_RANGE);
    q(CODE_UNIT, 32'h1);
    wr(9'h135, 32'h63);
    bad(9'h135, 32'h64, ERR_RANGE);
    q(9'h135, 32'h63);
    bad(9'h12E, 32'h0, ERR_RANGE);
    bad(9'h13E, 32'h2, ERR_RANGE);
    bad(9'h141, 32'h0, ERR_UNKNOWN);
    wr(CODE_UNIT, 32'h0);
    // store, then a power cycle
    wr(9'h12E, 32'h7D0);
    wr(9'h12F, 32'h3E8);
    wr(9'h130, 32'h1F4);
    wr(9'h133, 32'h5);
    wr(CODE_SPIN_RATIO, 32'h2);
    wr(CODE_SOFT_EN, 32'h1);
    wr(CODE_HOME_FIRST, 32'h1);
    wr(CODE_SOFT_FIRST, 32'hFFFF_FF00);
    io(1'b0, CODE_STORE, 32'h0, r);
    chk("store ok", 32'h1, 32'(r.ok));
    power_up();
    chk("ratio x", 32'h7D0, persist.ratio[0]);
    chk("ratio z", 32'h1F4, persist.ratio[2]);
    chk("dir mask", 32'h5, 32'(persist.dir_pol));
    chk("spin ratio", 32'h2, persist.spin_ratio);
    chk("soft enable", 32'h0, 32'(volat.soft_en));
    chk("homing", 32'h0, 32'(volat.homing));
    chk("soft x neg", SOFT_NEG_DEF, volat.soft_neg[0]);
    // pulse counts from per-axis ratios, one negative move
    @(posedge clk);
    #1;
    move_load = 1'b1;
    move_dist = {16'h0003, 16'h0002, 16'hFFFF};
    @(posedge clk);
    #1;
    move_load = 1'b0;
    chk("pulses x", 32'hFFFF_F830, pulse_count[0]);
    chk("pulses y", 32'h0000_07D0, pulse_count[1]);
    chk("pulses z", 32'h0000_05DC, pulse_count[2]);
    // step, direction and spindle outputs
    dir_raw = 3'b011;
    step_req = 3'b110;
    spin_step_req = 1'b1;
    spin_dir_raw = 1'b1;
    spin_speed = 16'h0010;
    @(posedge clk);
    #1;
    step_req = 3'b000;
    spin_step_req = 1'b0;
    chk("dir out", 32'(3'b011 ^ 3'b101), 32'(dir_out));
    chk("step out", 32'h6, 32'(step_pulse_out));
    chk("spin step", 32'h1, 32'(spin_step_out));
    chk("spin dir", 32'h1, 32'(spin_dir_out));
    chk("spin rate", 32'h20, spin_rate);
    @(posedge clk);
    #1;
    chk("step end", 32'h0, 32'(step_pulse_out));
    // buffer error causes
    err_pulses(1'b1, 1'b0, k);
    chk("arc unequal", 32'h1, 32'(k));
    wr(9'h12F, 32'h7D0);
    err_pulses(1'b1, 1'b0, k);
    chk("arc equal", 32'h0, 32'(k));
    buf_running = 1'b1;
    err_pulses(1'b0, 1'b1, k);
    chk("soft off", 32'h0, 32'(k));
    wr(CODE_SOFT_EN, 32'h1);
    err_pulses(1'b0, 1'b1, k);
    chk("soft on", 32'h1, 32'(k));
    buf_running = 1'b0;
    err_pulses(1'b0, 1'b1, k);
    chk("soft idle", 32'h0, 32'(k));
    // working unit apart from the system unit
    gcode_unit_set = 1'b1;
    gcode_unit_val = 1'b1;
    @(posedge clk);
    #1;
    gcode_unit_set = 1'b0;
    chk("working unit", 32'h1, 32'(working_unit));
    q(CODE_UNIT, 32'h0);
    // input polarity masks, each pattern then its inverse
    wr(9'h131, 32'h5);
    wr(9'h132, 32'h2);
    wr(9'h134, 32'h4);
    q(9'h131, 32'h5);
    for (int p = 0; p < 2; p++)
    begin
      {general_input, home_in, limit_minus_in, limit_plus_in} = p ? 12'h0A5 : 12'hF5A;
      repeat (4) @(posedge clk);
      #1;
      e = {~(general_input ^ 3'h4), ~(home_in ^ 3'h2), ~(limit_minus_in ^ 3'h5),
           ~(limit_plus_in ^ 3'h5)};
      chk("input levels", 32'(e), 32'(input_active));
    end
    end_of_test();
  end
endmodule

`default_nettype wire
